// ===== rtl/dpr_pkg.sv
// shared constants and types for the dual pcm interleave retimer
// How it works
// - no activity on input two blocks its sampling
// - timing pulses delayed 0.2 us before use
// - delayed timing returns through external traffic selector
// - first input samples lag further 0.87 us
// - half-bit offset kept in every mode
// - input two sampler emits one or zero pulse
// - both samplers share one and zero lines
// - merged pulses form one double-rate train
// - reshaper is set/reset storage element
// - reshaper starts at logic zero
// - input two direct or 0.4 us delayed path
// - input two reaches sampler with original polarity
// - phase bit toggles on timing at falling edge
// - phase correction only interleaved and separated modes
// - repeated same-value pulse leaves output unchanged
// - one pulse sets output to logic one
package dpr_pkg;
	localparam int CLK_MHZ = 250;
	localparam real BIT_NS = 1736.0;
	localparam real TIM_DLY_NS = 200.0;
	localparam real PH_DLY_NS = 400.0;
	localparam real HALF_DLY_NS = 870.0;
	localparam int CLK_NS = 1000 / CLK_MHZ;
	// nearest whole cycles of the 4 ns clock
	localparam int TIM_DLY_CYC = int'(TIM_DLY_NS / CLK_NS);
	localparam int PH_DLY_CYC = int'(PH_DLY_NS / CLK_NS);
	localparam int HALF_DLY_CYC = int'(HALF_DLY_NS / CLK_NS);
	localparam int BIT_CYC = int'(BIT_NS / CLK_NS);
	// loss of signal after this many bit times with no edge
	localparam int LOS_BITS = 16;
	localparam int LOS_CYC = LOS_BITS * BIT_CYC;
	localparam logic RESHAPE_RST = 1'b0;
	localparam logic PHASE_RST = 1'b0;

	typedef enum logic [1:0] {
		DPR_MODE_12CH,
		DPR_MODE_INTERLEAVED,
		DPR_MODE_SEPARATED,
		DPR_MODE_REPEATER
	} dpr_mode_type;

	typedef struct packed {
		logic one;
		logic zero;
	} dpr_pulse_type;
endpackage

// ===== rtl/dpr_delay.sv
// shift-register delay line counted in system clocks
module dpr_delay #(
	parameter int DEPTH = 1
) (
	input  wire logic i_clk,
	input  wire logic i_rst,
	input  wire logic i_d,
	output logic      o_q
);
	logic [DEPTH-1:0] line_q;

	// a one-stage line has no lower slice to shift, so it gets its own branch
	if (DEPTH == 1) begin : g_one
		always_ff @(posedge i_clk) begin
			if (i_rst) begin
				line_q <= '0;
			end else begin
				line_q <= i_d;
			end
		end
	end else begin : g_many
		always_ff @(posedge i_clk) begin
			if (i_rst) begin
				line_q <= '0;
			end else begin
				line_q <= {line_q[DEPTH-2:0], i_d};
			end
		end
	end

	assign o_q = line_q[DEPTH-1];
endmodule

// ===== rtl/dpr_buf2.sv
// two-entry buffer with valid and ready on both sides
module dpr_buf2 #(
	parameter int WIDTH = 1
) (
	input  wire logic             i_clk,
	input  wire logic             i_rst,
	input  wire logic [WIDTH-1:0] i_data,
	input  wire logic             i_valid,
	output logic                  o_ready,
	output logic      [WIDTH-1:0] o_data,
	output logic                  o_valid,
	input  wire logic             i_ready
);
	logic [WIDTH-1:0] mem_q [2];
	logic             wr_q;
	logic             rd_q;
	logic [1:0]       cnt_q;
	wire              push = i_valid && o_ready;
	wire              pop  = o_valid && i_ready;

	assign o_ready = (cnt_q != 2'h2);
	assign o_valid = (cnt_q != 2'h0);
	assign o_data  = mem_q[rd_q];

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			wr_q  <= 1'b0;
			rd_q  <= 1'b0;
			cnt_q <= 2'h0;
		end else begin
			if (push) begin
				wr_q <= ~wr_q;
			end
			if (pop) begin
				rd_q <= ~rd_q;
			end
			cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
		end
	end

	always_ff @(posedge i_clk) begin
		if (push) begin
			mem_q[wr_q] <= i_data;
		end
	end
endmodule

// ===== rtl/dpr_retimer.sv
// retimes and interleaves two pcm trains into one square-wave train
module dpr_retimer
	import dpr_pkg::*;
(
	input  wire logic                i_clk,
	input  wire logic                i_rst,
	input  wire dpr_pkg::dpr_mode_type i_mode,
	input  wire logic                i_pcm_in1,
	input  wire logic                i_pcm_in2,
	input  wire logic                i_bit_timing_input,
	output logic                     o_ch24_timing,
	input  wire logic                i_traffic_selector,
	output logic                     o_pcm_out,
	output logic                     o_pcm_out_valid,
	input  wire logic                i_pcm_out_ready,
	output logic                     o_in1_present,
	output logic                     o_in2_present,
	output logic                     o_phase_delayed,
	output logic                     o_overrun
);
	import dpr_pkg::*;

	// three-stage synchronisers; change counts when stages two and three agree
	logic [2:0] s_tim_q, s_in1_q, s_in2_q, s_sel_q;
	logic       tim_q, in1_q, in2_q, sel_q;

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			s_tim_q <= 3'h0;
			s_in1_q <= 3'h0;
			s_in2_q <= 3'h0;
			s_sel_q <= 3'h0;
			tim_q   <= 1'b0;
			in1_q   <= 1'b0;
			in2_q   <= 1'b0;
			sel_q   <= 1'b0;
		end else begin
			s_tim_q <= {s_tim_q[1:0], i_bit_timing_input};
			s_in1_q <= {s_in1_q[1:0], i_pcm_in1};
			s_in2_q <= {s_in2_q[1:0], i_pcm_in2};
			s_sel_q <= {s_sel_q[1:0], i_traffic_selector};
			if (s_tim_q[1] == s_tim_q[2]) begin
				tim_q <= s_tim_q[2];
			end
			if (s_in1_q[1] == s_in1_q[2]) begin
				in1_q <= s_in1_q[2];
			end
			if (s_in2_q[1] == s_in2_q[2]) begin
				in2_q <= s_in2_q[2];
			end
			if (s_sel_q[1] == s_sel_q[2]) begin
				sel_q <= s_sel_q[2];
			end
		end
	end

	// one timing pulse marks one bit of input two
	logic tim_d1_q;
	logic tim_pulse;
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			tim_d1_q <= 1'b0;
		end else begin
			tim_d1_q <= tim_q;
		end
	end
	assign tim_pulse = tim_q && !tim_d1_q;

	// delays are whole clock counts approximating the analog lines
	logic tim_dly;
	dpr_delay #(.DEPTH(TIM_DLY_CYC)) u_tim_dly (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_d  (tim_pulse),
		.o_q  (tim_dly)
	);

	// delayed timing leaves as 24-channel timing and returns via selector
	assign o_ch24_timing = tim_dly;

	logic sel_d1_q;
	logic samp2_tim;
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			sel_d1_q <= 1'b0;
		end else begin
			sel_d1_q <= sel_q;
		end
	end
	assign samp2_tim = sel_q && !sel_d1_q;

	// first input timing lags by half a bit in all modes
	logic samp1_tim;
	dpr_delay #(.DEPTH(HALF_DLY_CYC)) u_half_dly (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_d  (tim_dly),
		.o_q  (samp1_tim)
	);

	// loss-of-signal detectors: edge activity within LOS_CYC cycles
	logic [$clog2(LOS_CYC+1)-1:0] los1_q, los2_q;
	logic in1_d1_q, in2_d1_q;
	wire  in1_edge = in1_q ^ in1_d1_q;
	wire  in2_edge = in2_q ^ in2_d1_q;
	localparam logic [$clog2(LOS_CYC+1)-1:0] LOS_MAX = LOS_CYC[$clog2(LOS_CYC+1)-1:0];

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			in1_d1_q <= 1'b0;
			in2_d1_q <= 1'b0;
			los1_q   <= LOS_MAX;
			los2_q   <= LOS_MAX;
		end else begin
			in1_d1_q <= in1_q;
			in2_d1_q <= in2_q;
			if (in1_edge) begin
				los1_q <= '0;
			end else if (los1_q != LOS_MAX) begin
				los1_q <= los1_q + 1'b1;
			end
			if (in2_edge) begin
				los2_q <= '0;
			end else if (los2_q != LOS_MAX) begin
				los2_q <= los2_q + 1'b1;
			end
		end
	end
	// an all-ones or all-zeros train has no edges and reads as absent
	assign o_in1_present = (los1_q != LOS_MAX);
	assign o_in2_present = (los2_q != LOS_MAX);

	// phase correction: direct or delayed input two
	logic in2_late;
	dpr_delay #(.DEPTH(PH_DLY_CYC)) u_ph_dly (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_d  (in2_q),
		.o_q  (in2_late)
	);

	wire apc_on = (i_mode == DPR_MODE_INTERLEAVED) || (i_mode == DPR_MODE_SEPARATED);
	logic phase_q;
	logic path_d1_q;
	wire  path_in2   = phase_q ? in2_late : in2_q;
	wire  path_fall  = path_d1_q && !path_in2;
	// coincidence of timing with falling edge of the routed signal
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			phase_q   <= PHASE_RST;
			path_d1_q <= 1'b0;
		end else begin
			path_d1_q <= path_in2;
			if (!apc_on) begin
				phase_q <= PHASE_RST;
			end else if (tim_dly && path_fall) begin
				phase_q <= ~phase_q;
			end
		end
	end
	assign o_phase_delayed = phase_q;

	// two inversions cancel, so the sampler sees true polarity
	wire in2_inv   = ~path_in2;
	wire in2_samp  = ~in2_inv;

	// sampler two blocked by loss of signal and in 12-channel mode
	wire en2 = o_in2_present && (i_mode != DPR_MODE_12CH);
	wire en1 = o_in1_present;
	wire fire2 = samp2_tim && en2;
	wire fire1 = samp1_tim && en1;

	// per-sampler one/zero pulses, merged on shared lines
	dpr_pulse_type p1, p2, merged;
	assign p1.one  = fire1 && in1_q;
	assign p1.zero = fire1 && !in1_q;
	assign p2.one  = fire2 && in2_samp;
	assign p2.zero = fire2 && !in2_samp;
	assign merged.one  = p1.one | p2.one;
	assign merged.zero = p1.zero | p2.zero;

	// set/reset reshaper; zero at reset, repeats leave it unchanged
	logic reshape_q;
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			reshape_q <= RESHAPE_RST;
		end else if (merged.one) begin
			reshape_q <= 1'b1;
		end else if (merged.zero) begin
			reshape_q <= 1'b0;
		end
	end

	// each reshaper update is one bit of the double-rate output train
	logic bit_valid_q;
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			bit_valid_q <= 1'b0;
		end else begin
			bit_valid_q <= merged.one | merged.zero;
		end
	end

	// buffer absorbs a receiver stall; a full buffer drops the bit and flags it
	logic buf_ready;
	logic buf_data;
	dpr_buf2 #(.WIDTH(1)) u_buf (
		.i_clk  (i_clk),
		.i_rst  (i_rst),
		.i_data (reshape_q),
		.i_valid(bit_valid_q),
		.o_ready(buf_ready),
		.o_data (buf_data),
		.o_valid(o_pcm_out_valid),
		.i_ready(i_pcm_out_ready)
	);
	assign o_pcm_out = buf_data;

	logic overrun_q;
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			overrun_q <= 1'b0;
		end else if (bit_valid_q && !buf_ready) begin
			overrun_q <= 1'b1;
		end
	end
	assign o_overrun = overrun_q;
endmodule

// ===== verification/dpr_retimer_props.sv
// concurrent checks on the retimer top-level ports
module dpr_retimer_props
	import dpr_pkg::*;
(
	input wire logic         i_clk,
	input wire logic         i_rst,
	input wire dpr_mode_type i_mode,
	input wire logic         i_pcm_in1,
	input wire logic         i_pcm_in2,
	input wire logic         i_bit_timing_input,
	input wire logic         o_ch24_timing,
	input wire logic         i_traffic_selector,
	input wire logic         o_pcm_out,
	input wire logic         o_pcm_out_valid,
	input wire logic         i_pcm_out_ready,
	input wire logic         o_in1_present,
	input wire logic         o_in2_present,
	input wire logic         o_phase_delayed,
	input wire logic         o_overrun
);
	logic ph_ok;
	assign ph_ok = i_mode == DPR_MODE_INTERLEAVED || i_mode == DPR_MODE_SEPARATED;
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_rst);
	a_reset_clear: assert property ($fell(i_rst) |-> !o_pcm_out_valid && !o_overrun
		&& !o_phase_delayed && !o_in1_present && !o_in2_present) else $error("reset state");
	// sync plus delay line, with slack for the sync stages
	a_ch24_delay: assert property ($rose(i_bit_timing_input) |-> ##[48:60] o_ch24_timing)
		else $error("timing delay");
	a_ch24_single: assert property (o_ch24_timing |=> !o_ch24_timing [*8])
		else $error("timing pulse");
	a_no_phase: assert property (!ph_ok [*3] |-> !o_phase_delayed)
		else $error("phase outside mode");
	a_valid_hold: assert property (o_pcm_out_valid && !i_pcm_out_ready
		|=> o_pcm_out_valid && $stable(o_pcm_out)) else $error("stall lost");
	a_overrun_keep: assert property (o_overrun |=> o_overrun)
		else $error("overrun cleared");
	a_overrun_full: assert property ($rose(o_overrun) |-> $past(o_pcm_out_valid))
		else $error("overrun while empty");
	a_no_source: assert property (!o_pcm_out_valid && !o_in1_present && !o_in2_present
		|=> !o_pcm_out_valid) else $error("word without input");
endmodule

// ===== verification/dpr_mux_model.sv
// companion multiplexer model: timing, two data trains, selector loop
module dpr_mux_model
	import dpr_pkg::*;
(
	input  wire logic       i_clk,
	input  wire logic       i_en2,
	input  wire logic [7:0] i_p1,
	input  wire logic [7:0] i_p2,
	input  wire logic       i_ch24,
	output logic            o_tim,
	output logic            o_in1,
	output logic            o_in2,
	output logic            o_sel
);
	timeunit 1ns;
	timeprecision 1ps;
	int c = 0;
	int k = 0;
	int s = 0;
	always @(posedge i_clk) begin
		c <= (c == BIT_CYC - 1) ? 0 : c + 1;
		if (c == BIT_CYC - 1) begin
			k <= k + 1;
		end
	end
	assign o_tim = c < 8;
	assign o_in1 = i_p1[k % 8];
	// a quiet second train is held low: no activity at all
	assign o_in2 = i_en2 & i_p2[k % 8];
	// the selector loop stretches the one-cycle timing so the retimer's
	// three-stage synchroniser sees it in two stages at once
	always @(posedge i_clk) begin
		if (i_ch24) begin
			s <= 8;
		end else if (s != 0) begin
			s <= s - 1;
		end
	end
	assign o_sel = (s != 0);
endmodule

// ===== verification/tb.sv
// self-checking bench for the retimer
module tb;
	import dpr_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {
		dpr_mode_type m;
		logic         en2;
		logic [7:0]   p1;
		logic [7:0]   p2;
		logic [7:0]   ones;
	} dpr_row_type;
	dpr_row_type rows [5] = '{
		'{DPR_MODE_12CH, 1'b1, 8'h0f, 8'h3c, 8'h08},
		'{DPR_MODE_INTERLEAVED, 1'b1, 8'h33, 8'h01, 8'h05},
		'{DPR_MODE_SEPARATED, 1'b1, 8'h55, 8'h0f, 8'h08},
		'{DPR_MODE_REPEATER, 1'b1, 8'h01, 8'h3f, 8'h07},
		'{DPR_MODE_INTERLEAVED, 1'b0, 8'h0f, 8'hff, 8'h08}
	};
	logic i_clk = 1'b0;
	logic i_rst = 1'b1;
	dpr_mode_type mode = DPR_MODE_12CH;
	logic rdy = 1'b1;
	logic en2 = 1'b0;
	logic [7:0] p1 = 8'h00;
	logic [7:0] p2 = 8'h00;
	logic in1, in2, tim, sel, ch24, dout, dval, pr1, pr2, phd, ovr;
	logic [15:0] hist = 16'h0000;
	int bad_count = 0;
	int n_tests = 0;
	always #2 i_clk = ~i_clk;
	dpr_mux_model mux (.i_clk(i_clk), .i_en2(en2), .i_p1(p1), .i_p2(p2), .i_ch24(ch24),
		.o_tim(tim), .o_in1(in1), .o_in2(in2), .o_sel(sel));
	dpr_retimer uut (.i_clk(i_clk), .i_rst(i_rst), .i_mode(mode), .i_pcm_in1(in1),
		.i_pcm_in2(in2), .i_bit_timing_input(tim), .o_ch24_timing(ch24),
		.i_traffic_selector(sel), .o_pcm_out(dout), .o_pcm_out_valid(dval),
		.i_pcm_out_ready(rdy), .o_in1_present(pr1), .o_in2_present(pr2),
		.o_phase_delayed(phd), .o_overrun(ovr));
	// only popped words count, so a stall cannot double a bit
	always @(posedge i_clk) begin
		if (dval === 1'b1 && rdy) begin
			hist <= {hist[14:0], dout};
		end
	end
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED t=%0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	initial begin
		repeat (3) @(posedge i_clk);
		i_rst <= 1'b0;
		foreach (rows[i]) begin
			@(posedge i_clk);
			mode <= rows[i].m;
			en2 <= rows[i].en2;
			p1 <= rows[i].p1;
			p2 <= rows[i].p2;
			// 16 popped words span whole pattern periods in every mode
			repeat (36 * BIT_CYC) @(posedge i_clk);
			chk(8'($countones(hist)), rows[i].ones);
		end
		rdy <= 1'b0;
		repeat (4 * BIT_CYC) @(posedge i_clk);
		#1;
		chk(8'(dval), 8'h01);
		chk(8'(ovr), 8'h01);
		@(posedge i_clk);
		i_rst <= 1'b1;
		repeat (3) @(posedge i_clk);
		#1;
		chk({5'h00, dval, ovr, phd}, 8'h00);
		chk({6'h00, pr1, pr2}, 8'h00);
		stop_test();
	end
	initial begin
		#400000;
		bad_count++;
		stop_test();
	end
endmodule
bind dpr_retimer dpr_retimer_props props_i (.*);
